// ---- src/bsu_top.sv ----
// buffered serial unit: apb registers, 32-byte buffer and shift engine
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module bsu_top
    import bsu_pkg::*;
#(
    parameter int AW    = 18,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // serial pins
    input  wire logic          shift_clock_pin_i,
    output logic               shift_clock_pin_o,
    output logic               shift_clock_pin_oe,
    input  wire logic          serial_in_pin,
    output logic               serial_out_pin_o,
    output logic               serial_out_pin_oe,
    output logic               byte_strobe_pin,
    input  wire logic          chip_select_n,
    // interrupt
    output logic               irq
);

    logic [7:0]   buffer [DEPTH];
    logic [4:0]   first_index_field;
    logic [4:0]   last_index_field;
    bsu_ctl_s     ctl;
    logic         run_flag;
    logic         cancel_flag;
    logic         wait_flag;
    logic         clock_excess_flag;
    logic [3:1]   read_seen;
    logic [2:0]   evt_status;
    logic [2:0]   evt_mask;
    logic [2:0]   option;
    bsu_state_e   state;
    logic [7:0]   half_cnt;
    logic [5:0]   gap_cnt;
    logic [7:0]   sreg;
    logic [2:0]   bit_cnt;
    logic [4:0]   cur_idx;
    logic         sck_q;
    logic         sck_prev;
    logic         so_q;
    logic         hiz;

    // bus decode
    logic [15:0]  idx;
    logic         setup;
    logic         access;
    logic         wr;
    logic         rd;
    logic         buf_hit;
    logic [4:0]   buf_sel;
    logic         mapped;

    assign idx     = paddr[17:2];
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wr      = access & pwrite;
    assign rd      = access & ~pwrite;
    assign buf_hit = (idx >= IDX_BUF_BASE) && (idx <= IDX_BUF_LAST) && (paddr[1:0] == 2'h0);
    assign buf_sel = paddr[6:2];
    assign mapped  = buf_hit || ((paddr[1:0] == 2'h0) &&
                     (idx >= IDX_FIRST) && (idx <= IDX_OPTION));
    // zero wait states; read data is prepared during setup
    assign pready  = 1'b1;

    // engine events
    logic ext_mode;
    logic in_xfer;
    logic tick;
    logic fall_ev;
    logic rise_ev;
    logic byte_end;
    logic last_byte;
    logic done_ev;
    logic cs_abort;
    logic sw_stop;
    logic start_req;
    logic gap_on;
    logic excess_ev;
    logic buf_blocked;
    logic [4:0] next_idx;
    logic [7:0] rx_byte;

    assign ext_mode  = (ctl.cks == CLK_EXT);
    assign in_xfer   = (state == ST_SHIFT) || (state == ST_GAP);
    assign tick      = (half_cnt == 8'h00);
    // external clock pin is taken as synchronous; edges seen against last sample
    assign fall_ev   = (state == ST_SHIFT) &&
                       (ext_mode ? (sck_prev & ~shift_clock_pin_i) : (tick & sck_q));
    assign rise_ev   = (state == ST_SHIFT) &&
                       (ext_mode ? (~sck_prev & shift_clock_pin_i) : (tick & ~sck_q));
    assign byte_end  = rise_ev && (bit_cnt == 3'h7);
    assign last_byte = (cur_idx == last_index_field);
    assign done_ev   = byte_end & last_byte;
    assign next_idx  = cur_idx + 5'h01;
    assign rx_byte   = {serial_in_pin, sreg[7:1]};
    assign gap_on    = ~ext_mode && (ctl.gap != 2'h0);
    assign cs_abort  = option[OPT_CS] & chip_select_n & in_xfer;
    assign sw_stop   = wr && (idx == IDX_STATE) && !pwdata[RUN_BIT] && run_flag;
    assign start_req = wr && (idx == IDX_STATE) && pwdata[RUN_BIT] && !run_flag &&
                       !cancel_flag;
    assign excess_ev = ext_mode && (state == ST_IDLE) && ~sck_prev && shift_clock_pin_i &&
                       !(option[OPT_CS] & chip_select_n);
    assign buf_blocked = run_flag;

    // sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state <= option[OPT_CS] ? ST_WAIT : ST_SHIFT;
                    end
                end
                ST_WAIT: begin
                    if (sw_stop) begin
                        state <= ST_IDLE;
                    end else if (!chip_select_n) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (cs_abort || sw_stop || done_ev) begin
                        state <= ST_IDLE;
                    end else if (byte_end && gap_on) begin
                        state <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (cs_abort || sw_stop) begin
                        state <= ST_IDLE;
                    end else if (gap_cnt == 6'h01) begin
                        state <= ST_SHIFT;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // shift clock generation and gap timing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_cnt <= 8'h00;
            gap_cnt  <= 6'h00;
            sck_q    <= 1'b1;
        end else begin
            if (state != ST_SHIFT) begin
                // idle and gap hold the clock high
                sck_q    <= 1'b1;
                half_cnt <= bsu_half_len(ctl.cks) - 8'h01;
            end else if (tick) begin
                sck_q    <= ~sck_q;
                half_cnt <= bsu_half_len(ctl.cks) - 8'h01;
            end else begin
                half_cnt <= half_cnt - 8'h01;
            end
            if (byte_end) begin
                gap_cnt <= bsu_gap_len(ctl.gap);
            end else if (state == ST_GAP) begin
                gap_cnt <= gap_cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= shift_clock_pin_i;
        end
    end

    // data path: shift register, bit and byte position
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sreg    <= 8'h00;
            bit_cnt <= 3'h0;
            cur_idx <= 5'h00;
        end else begin
            if ((state != ST_SHIFT) && (state != ST_GAP)) begin
                sreg    <= buffer[first_index_field];
                cur_idx <= first_index_field;
                bit_cnt <= 3'h0;
            end else if (byte_end) begin
                sreg    <= buffer[next_idx];
                cur_idx <= next_idx;
                bit_cnt <= 3'h0;
            end else if (rise_ev) begin
                sreg    <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    // buffer: cpu access when idle, received bytes during a transfer; no reset
    always_ff @(posedge clk) begin
        if (byte_end && option[OPT_RX]) begin
            buffer[cur_idx] <= rx_byte;
        end else if (wr && buf_hit && !buf_blocked) begin
            buffer[buf_sel] <= pwdata[7:0];
        end
    end

    // serial output pin and drive enables
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            so_q <= 1'b0;
            hiz  <= 1'b0;
        end else begin
            if (fall_ev) begin
                so_q <= sreg[0];
            end else if (wr && (idx == IDX_STATE) && !run_flag) begin
                so_q <= pwdata[SOL_BIT];
            end
            if (cs_abort) begin
                hiz <= 1'b1;
            end else if (start_req) begin
                hiz <= 1'b0;
            end
        end
    end

    assign shift_clock_pin_o  = sck_q;
    assign shift_clock_pin_oe = ~ext_mode & ~hiz;
    assign serial_out_pin_o   = so_q;
    assign serial_out_pin_oe  = ~hiz;

    // strobe covers each gap, so it pulses once between bytes, not after the last, and never without a gap
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byte_strobe_pin <= 1'b0;
        end else begin
            byte_strobe_pin <= option[OPT_STROBE] && gap_on &&
                               ((byte_end && !last_byte && !sw_stop && !cs_abort) ||
                                ((state == ST_GAP) && (gap_cnt != 6'h01) &&
                                 !sw_stop && !cs_abort));
        end
    end

    // control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_index_field <= REG_RESET[4:0];
            last_index_field  <= REG_RESET[4:0];
            ctl               <= REG_RESET[4:0];
            evt_mask          <= 3'h0;
            option            <= 3'h0;
        end else if (wr) begin
            case (idx)
                IDX_FIRST:    first_index_field <= pwdata[4:0];
                IDX_LAST:     last_index_field  <= pwdata[4:0];
                IDX_CLKGAP:   ctl               <= pwdata[4:0];
                IDX_EVT_MASK: evt_mask          <= pwdata[2:0];
                IDX_OPTION:   option            <= pwdata[2:0];
                default:      ;
            endcase
        end
    end

    // run flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_flag <= 1'b0;
        end else if (start_req) begin
            run_flag <= 1'b1;
        end else if (done_ev || cs_abort || sw_stop) begin
            run_flag <= 1'b0;
        end
    end

    // sticky flags: clear by writing zero after a read saw them set; a set wins
    logic clr_ok_exc;
    logic clr_ok_wait;
    logic clr_ok_cancel;
    logic buf_denied;
    assign clr_ok_exc    = wr && (idx == IDX_STATE) && !pwdata[EXCESS_BIT] && read_seen[3];
    assign clr_ok_wait   = wr && (idx == IDX_STATE) && !pwdata[WAIT_BIT] && read_seen[2];
    assign clr_ok_cancel = wr && (idx == IDX_STATE) && !pwdata[CANCEL_BIT] && read_seen[1];
    assign buf_denied    = access && buf_hit && buf_blocked;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clock_excess_flag <= 1'b0;
            wait_flag         <= 1'b0;
            cancel_flag       <= 1'b0;
            read_seen         <= 3'h0;
        end else begin
            clock_excess_flag <= excess_ev | (clock_excess_flag & ~clr_ok_exc);
            wait_flag         <= buf_denied | (wait_flag & ~clr_ok_wait);
            cancel_flag       <= cs_abort | (cancel_flag & ~clr_ok_cancel);
            if (rd && (idx == IDX_STATE)) begin
                read_seen <= read_seen | {clock_excess_flag, wait_flag, cancel_flag};
            end else if (wr && (idx == IDX_STATE)) begin
                read_seen <= read_seen & {~clr_ok_exc, ~clr_ok_wait, ~clr_ok_cancel};
            end
        end
    end

    // interrupt events: write one to clear, a new event wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_status <= 3'h0;
        end else begin
            evt_status <= {excess_ev, cs_abort, done_ev} |
                          (evt_status & ~((wr && (idx == IDX_EVT_ST)) ? pwdata[2:0] : 3'h0));
        end
    end

    assign irq = |(evt_status & evt_mask);

    // read data captured in the setup phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !mapped;
            prdata  <= 32'h0;
            if (buf_hit) begin
                prdata[7:0] <= buf_blocked ? 8'h00 : buffer[buf_sel];
            end else begin
                case (idx)
                    IDX_FIRST:    prdata[7:0] <= {RESV_ONES, first_index_field};
                    IDX_LAST:     prdata[7:0] <= {RESV_ONES, last_index_field};
                    IDX_CLKGAP:   prdata[7:0] <= {RESV_ONES, ctl};
                    IDX_STATE:    prdata[7:0] <= {RESV_ONES, so_q, clock_excess_flag,
                                                  wait_flag, cancel_flag, run_flag};
                    IDX_EVT_ST:   prdata[2:0] <= evt_status;
                    IDX_EVT_MASK: prdata[2:0] <= evt_mask;
                    IDX_OPTION:   prdata[2:0] <= option;
                    default:      prdata      <= 32'h0;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_gap_clock_high: assert property (state == ST_GAP |-> shift_clock_pin_o)
        else $error("shift clock not high during gap");
    a_strobe_no_gap: assert property (ctl.gap == 2'h0 && $past(ctl.gap) == 2'h0
        |-> !byte_strobe_pin)
        else $error("strobe active without gap");
    a_ext_no_gap: assert property (ext_mode && byte_end && !last_byte && !sw_stop
        && !cs_abort |=> state == ST_SHIFT)
        else $error("gap inserted with external clock");
    a_gap_eight: assert property ($rose(state == ST_GAP) && ctl.gap == 2'h1 && !cs_abort
        && !sw_stop |-> (state == ST_GAP)[*8] ##1 state == ST_SHIFT)
        else $error("gap of code 01 not eight cycles");
    a_reserved_ones: assert property (setup && !pwrite && idx == IDX_CLKGAP
        |=> prdata[7:5] == 3'h7)
        else $error("reserved bits not read as one");
    a_abort_float: assert property (cs_abort |=> !shift_clock_pin_oe && !serial_out_pin_oe
        && cancel_flag && !run_flag && evt_status[EVT_CANCEL])
        else $error("abort did not float pins");
    a_done_irq: assert property (done_ev |=> !run_flag && evt_status[EVT_DONE]
        && state == ST_IDLE)
        else $error("completion not flagged");
    a_index_step: assert property (byte_end && !last_byte |=> cur_idx == $past(next_idx))
        else $error("buffer index did not ascend");
    a_div2_toggle: assert property (state == ST_SHIFT && $past(state) == ST_SHIFT
        && ctl.cks == 3'h6 && $past(ctl.cks) == 3'h6 |-> sck_q != $past(sck_q))
        else $error("divide by two clock not toggling");
    a_excess_set: assert property (excess_ev |=> clock_excess_flag)
        else $error("overrun not flagged");

    c_done: cover property (done_ev);
    c_abort: cover property (cs_abort);
    c_gap: cover property ($rose(state == ST_GAP));
    c_excess: cover property (excess_ev);

endmodule

// ---- src/bsu_pkg.sv ----
// constants, types and decode helpers of the buffered serial unit
// Function
// - 32-byte buffer, block transfer in one go
// - first index register holds 5-bit start
// - last index register holds 5-bit end
// - equal indices move exactly one byte
// - bits 7..5 read one, reset e0
// - gap codes: none, 8, 24, 56 cycles
// - gaps only with internal shift clock
// - shift clock pin high during gap
// - strobe stays low without gap
// - clock select: seven dividers or external
// - one strobe pulse per gap between bytes
// - chip select may start a transfer
// - interrupt on completion and on error
// - control registers at ffa4..ffa7
// - lsb first, out on fall, sample rise
// - run flag starts, busy, zero aborts
// - chip select high aborts, tri-states pins
// - external clock after completion sets overrun
package bsu_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_BUF_BASE = 16'hff80;
    localparam logic [15:0] IDX_BUF_LAST = 16'hff9f;
    localparam logic [15:0] IDX_FIRST    = 16'hffa4;
    localparam logic [15:0] IDX_LAST     = 16'hffa5;
    localparam logic [15:0] IDX_CLKGAP   = 16'hffa6;
    localparam logic [15:0] IDX_STATE    = 16'hffa7;
    localparam logic [15:0] IDX_EVT_ST   = 16'hffa8;
    localparam logic [15:0] IDX_EVT_MASK = 16'hffa9;
    localparam logic [15:0] IDX_OPTION   = 16'hffaa;

    localparam logic [7:0] REG_RESET  = 8'he0;
    localparam logic [2:0] RESV_ONES  = 3'h7;

    // transfer_state_control fields
    localparam int SOL_BIT    = 4;
    localparam int EXCESS_BIT = 3;
    localparam int WAIT_BIT   = 2;
    localparam int CANCEL_BIT = 1;
    localparam int RUN_BIT    = 0;

    // event status / mask fields
    localparam int EVT_DONE   = 0;
    localparam int EVT_CANCEL = 1;
    localparam int EVT_EXCESS = 2;

    // option register fields
    localparam int OPT_CS     = 0;
    localparam int OPT_STROBE = 1;
    localparam int OPT_RX     = 2;

    localparam logic [2:0] CLK_EXT = 3'h7;

    localparam logic [5:0] GAP_LEN_1 = 6'h08;
    localparam logic [5:0] GAP_LEN_2 = 6'h18;
    localparam logic [5:0] GAP_LEN_3 = 6'h38;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_SHIFT = 2'h3,
        ST_GAP  = 2'h2
    } bsu_state_e;

    typedef struct packed {
        logic [1:0] gap;
        logic [2:0] cks;
    } bsu_ctl_s;

    // half period of the shift clock in system clocks
    function automatic logic [7:0] bsu_half_len(input logic [2:0] cks);
        case (cks)
            3'h0:    bsu_half_len = 8'h80;
            3'h1:    bsu_half_len = 8'h20;
            3'h2:    bsu_half_len = 8'h10;
            3'h3:    bsu_half_len = 8'h08;
            3'h4:    bsu_half_len = 8'h04;
            3'h5:    bsu_half_len = 8'h02;
            default: bsu_half_len = 8'h01;
        endcase
    endfunction

    function automatic logic [5:0] bsu_gap_len(input logic [1:0] gap);
        case (gap)
            2'h1:    bsu_gap_len = GAP_LEN_1;
            2'h2:    bsu_gap_len = GAP_LEN_2;
            2'h3:    bsu_gap_len = GAP_LEN_3;
            default: bsu_gap_len = 6'h00;
        endcase
    endfunction

endpackage

// ---- bench/bsu_peer.sv ----
// serial peer model: samples the data line and answers on the shift clock
`timescale 1ns/1ps
module bsu_peer (
    // system clock, only for measuring intervals
    input  wire logic clk,
    // serial pins
    input  wire logic sck,
    input  wire logic so,
    input  wire logic strobe,
    output logic      si
);
    logic [7:0] sh = 8'h00;
    logic [7:0] got[$];
    int         nb = 0;
    int         cyc = 0;
    int         last = 0;
    int         minp = 0;
    int         maxp = 0;
    int         strobes = 0;

    initial si = 1'b0;

    task automatic clear();
        got.delete();
        nb = 0;
        last = 0;
        minp = 0;
        maxp = 0;
        strobes = 0;
    endtask

    // lsb first, taken on the rising edge
    always @(posedge sck) begin
        sh = {so, sh[7:1]};
        nb = nb + 1;
        if (nb == 8) begin
            got.push_back(sh);
            nb = 0;
        end
        if (last != 0 && (minp == 0 || cyc - last < minp)) begin
            minp = cyc - last;
        end
        if (last != 0 && cyc - last > maxp) begin
            maxp = cyc - last;
        end
        last = cyc;
    end

    // answer changes on the falling edge, never stands still
    always @(negedge sck) begin
        si <= ~si;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    always @(posedge strobe) begin
        strobes = strobes + 1;
    end
endmodule

// ---- bench/buffered_sync_serial_port_tb_top.sv ----
// self-checking bench of the buffered serial unit
`timescale 1ns/1ps
module buffered_sync_serial_port_tb_top;
    import bsu_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] r;
    logic        pready, pslverr, err, sck_o, sck_oe, so_o, so_oe, strobe, irq, si;
    logic        ext_sck = 1'b1;
    logic [1:0]  ext_ph = 2'h0;
    logic        ext_en = 1'b0;
    logic        cs_n = 1'b1;
    logic [7:0]  mem [32];
    logic [7:0]  seed = 8'h32;
    int          fail_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          ext_goal = 0;
    int          ext_done = 0;
    // released clock line is pulled up, so no stray edges reach the peer
    wire         sck = sck_oe ? sck_o : (ext_en ? ext_sck : 1'b1);

    bsu_top uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .shift_clock_pin_i(sck),
        .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .serial_in_pin(si),
        .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .byte_strobe_pin(strobe),
        .chip_select_n(cs_n), .irq(irq));
    bsu_peer peer (.clk(clk), .sck(sck), .so(so_o), .strobe(strobe), .si(si));

    always #2.5 clk = ~clk;

    // external clock: pulses of four system clocks until the asked count is reached
    always @(posedge clk) begin
        if (ext_done != ext_goal) begin
            ext_ph  <= ext_ph + 2'h1;
            ext_sck <= ext_ph[1];
            if (ext_ph == 2'h3) begin
                ext_done <= ext_done + 1;
            end
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // whole run is a few thousand cycles; this only cuts a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic int div_of(input int c);
        // external period is the bench's own pulse of four clocks
        return (c == 0) ? 256 : (c == 7) ? 4 : (128 >> c);
    endfunction

    function automatic int gap_of(input int g);
        return (g == 0) ? 0 : (1 << (g + 3)) - 8;
    endfunction

    task automatic xfer(input logic [4:0] f, input logic [2:0] n, input logic [1:0] g,
                        input logic [2:0] c);
        int k;
        int e;
        peer.clear();
        apb(1'b1, IDX_FIRST, {3'h0, f});
        apb(1'b1, IDX_LAST, {3'h0, f + 5'(n - 3'h1)});
        apb(1'b1, IDX_CLKGAP, {3'h0, g, c});
        apb(1'b1, IDX_STATE, 8'h01);
        if (c == CLK_EXT) begin
            ext_goal <= ext_goal + 8 * n;
        end
        k = 0;
        do begin
            apb(1'b0, IDX_STATE, 8'h00);
            k++;
        end while (r[0] !== 1'b0 && k < 1000);
        chk("run flag", 32'h0, 32'(r[0]));
        chk("byte count", 32'(n), peer.got.size());
        for (int i = 0; i < n; i++) begin
            chk("byte", 32'(mem[5'(f + 5'(i))]), 32'(peer.got[i]));
        end
        chk("shift period", div_of(c), peer.minp);
        e = div_of(c) + ((c == CLK_EXT) ? 0 : gap_of(g));
        if (n > 1) begin
            chk("gap span", 32'h1, 32'(peer.maxp >= e && peer.maxp <= e + 2));
        end
        chk("strobes", (g != 0 && c != CLK_EXT) ? n - 1 : 0, peer.strobes);
        @(negedge clk);
        chk("irq done", 32'h1, 32'(irq));
        apb(1'b1, IDX_EVT_ST, 8'h01);
        @(negedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
    endtask

    initial begin
        logic [2:0] n;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, IDX_FIRST + 16'(i), 8'h00);
            chk("reset value", 32'he0, r);
            // run bit kept low here: a start would block the buffer for the rest of the run
            apb(1'b1, IDX_FIRST + 16'(i), (i == 3) ? 8'h1e : 8'h1f);
            apb(1'b0, IDX_FIRST + 16'(i), 8'h00);
            chk("field write", (i == 3) ? 32'hf0 : 32'hff, r);
        end
        apb(1'b0, 16'hffb0, 8'h00);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped read", 32'h0, r);
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            mem[i] = seed;
            apb(1'b1, IDX_BUF_BASE + 16'(i), seed);
        end
        apb(1'b0, IDX_BUF_LAST, 8'h00);
        chk("buffer read", 32'(mem[31]), r);
        apb(1'b1, IDX_OPTION, 8'h02);
        apb(1'b1, IDX_EVT_MASK, 8'h03);
        for (int c = 0; c < 7; c++) begin
            xfer(5'(c * 3), 3'h1, 2'h0, 3'(c));
        end
        xfer(5'h1e, 3'h4, 2'h3, 3'h5);
        repeat (4) begin
            seed = lfsr(seed);
            n = {1'b0, seed[6:5]} + 3'h1;
            xfer(seed[4:0], n, 2'(lfsr(seed) % 4), 3'h6);
        end
        // chip-select start, then abort mid-byte
        apb(1'b1, IDX_OPTION, 8'h03);
        apb(1'b1, IDX_CLKGAP, 8'h06);
        apb(1'b1, IDX_STATE, 8'h01);
        apb(1'b0, IDX_STATE, 8'h00);
        chk("waiting for select", 32'h1, 32'(r[0]));
        apb(1'b0, IDX_BUF_BASE, 8'h00);
        chk("blocked read", 32'h0, r);
        cs_n <= 1'b0;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk("pins released", 32'h0, {sck_oe, so_oe});
        chk("irq abort", 32'h1, 32'(irq));
        apb(1'b0, IDX_STATE, 8'h00);
        chk("abort flags", 32'h6, 32'(r[2:0]));
        apb(1'b1, IDX_STATE, 8'h00);
        apb(1'b0, IDX_STATE, 8'h00);
        chk("flags cleared", 32'h0, 32'(r[3:0]));
        apb(1'b1, IDX_EVT_ST, 8'h07);
        apb(1'b0, IDX_BUF_BASE, 8'h00);
        chk("buffer kept", 32'(mem[0]), r);
        // external clock pulse while idle
        apb(1'b1, IDX_OPTION, 8'h00);
        apb(1'b1, IDX_CLKGAP, 8'h1f);
        ext_en   <= 1'b1;
        ext_goal <= ext_goal + 1;
        repeat (8) @(posedge clk);
        apb(1'b0, IDX_STATE, 8'h00);
        chk("overrun flag", 32'h1, 32'(r[3]));
        apb(1'b0, IDX_EVT_ST, 8'h00);
        chk("overrun event", 32'h1, 32'(r[2]));
        chk("masked irq", 32'h0, 32'(irq));
        apb(1'b1, IDX_STATE, 8'h00);
        apb(1'b0, IDX_STATE, 8'h00);
        chk("overrun cleared", 32'h0, 32'(r[3]));
        // external clock transfer: gap and strobe settings must have no effect
        apb(1'b1, IDX_OPTION, 8'h02);
        xfer(5'h02, 3'h2, 2'h3, CLK_EXT);
        tally_and_finish();
    end
endmodule
